// ==== cskip_exec.sv ====
// compare-and-skip execution: decode, operand read, compare, skip cycles
// assumes the core feeds the word at Q1 and memory data by the end of Q2
// Operation
// - decode greater-than form 0110 010a ffffffff
// - skip when operand strictly above working register
// - decode less-than form 0110 000a ffffffff
// - skip when operand strictly below working register
// - taken skip runs one no-operation cycle, two over a two-word instruction
// - bank bit zero selects fixed access bank
// - bank bit one uses bank select register
// - one word; one cycle, two if skipping
// - skipping two-word instruction takes three cycles
// - no status flag ever changes
// - skip cycles do nothing in all phases
`timescale 1ns/1ps
`include "cskip_cfg.svh"
module cskip_exec
    import cskip_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // instruction from the fetch stage
    input wire logic instr_valid,
    input wire cskip_instr_s instr,
    input wire logic next_two_word,
    // core registers
    input wire logic [7:0] working_register,
    input wire logic [3:0] bank_select_register,
    // data memory
    output cskip_mem_s mem_r,
    input wire logic [7:0] mem_rdata,
    // core control
    output cskip_phase_t phase_r,
    output logic flush_r,
    output logic nop_r,
    output logic done_r,
    output logic status_we_r
);

    logic rst_m_r; // reset synchroniser first stage
    logic rst_n_r; // synchronised reset
    cskip_state_e state_r; // execution state
    logic act_r; // compare executing this cycle
    logic gt_r; // greater-than form latched
    logic [7:0] opnd_r; // operand read in Q2
    logic take_r; // skip decision from Q3
    logic two_r; // skipped word is two words long

    // release reset through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // phase generator
    cskip_phase u_phase (
        .clk(clk),
        .rst_n(rst_n_r),
        .ce(ce),
        .phase_r(phase_r)
    );

    // phase strobes
    wire q1 = phase_r[0];
    wire q2 = phase_r[1];
    wire q3 = phase_r[2];
    wire q4 = phase_r[3];
    wire run = (state_r == CSK_ST_RUN);

    // opcode decode
    wire hi_ok = (instr.op_hi == `CSK_OP_HI);
    wire is_gt = hi_ok && (instr.sel == `CSK_GT_SEL);
    wire is_lt = hi_ok && (instr.sel == `CSK_LT_SEL);
    wire accept = ce && q1 && run && instr_valid && (is_gt || is_lt);

    // operand address: access bank or bank select register
    wire acc_lo = (instr.faddr < `CSK_ACC_SPLIT);
    wire [3:0] acc_bank = acc_lo ? `CSK_ACC_LO_BANK : `CSK_ACC_HI_BANK;
    wire [3:0] bank = instr.bank_a ? bank_select_register : acc_bank;
    wire [11:0] addr_nxt = {bank, instr.faddr};

    // unsigned compare on the latched operand
    wire above = (opnd_r > working_register);
    wire below = (opnd_r < working_register);
    wire take_nxt = gt_r ? above : below;

    // end of an instruction cycle
    wire cyc_end = ce && q4;
    wire exec_end = cyc_end && act_r;

    // memory read strobe: raised through Q2 only
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mem_r <= {1'b0, `CSK_ADDR_RST};
        end else if (accept) begin
            mem_r <= {1'b1, addr_nxt};
        end else if (ce && q2) begin
            mem_r.rd_en <= 1'b0;
        end
    end

    // decode latch and operand capture
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            act_r <= 1'b0;
            gt_r <= 1'b0;
            opnd_r <= 8'h00;
        end else if (accept) begin
            act_r <= 1'b1;
            gt_r <= is_gt;
        end else if (ce && q2 && act_r) begin
            opnd_r <= mem_rdata;
        end else if (exec_end) begin
            act_r <= 1'b0;
        end
    end

    // compare in Q3
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            take_r <= 1'b0;
        end else if (ce && q3 && act_r) begin
            take_r <= take_nxt;
        end else if (exec_end) begin
            take_r <= 1'b0;
        end
    end

    // skip sequencing at the end of each cycle
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= CSK_ST_RUN;
            two_r <= 1'b0;
        end else if (cyc_end) begin
            case (state_r)
                CSK_ST_RUN: begin
                    if (act_r && take_r) begin
                        state_r <= CSK_ST_SKIP1;
                        two_r <= next_two_word;
                    end
                end
                CSK_ST_SKIP1: begin
                    state_r <= two_r ? CSK_ST_SKIP2 : CSK_ST_RUN;
                end
                CSK_ST_SKIP2: begin
                    state_r <= CSK_ST_RUN;
                    two_r <= 1'b0;
                end
                default: begin
                    state_r <= CSK_ST_RUN;
                end
            endcase
        end
    end

    // control outputs: flush, no-op marker, completion
    wire skip_go = exec_end && take_r;
    wire nop_nxt = skip_go || (!run && !(state_r == CSK_ST_SKIP1 && !two_r)
                   && !(state_r == CSK_ST_SKIP2));
    wire fin_nxt = (exec_end && !take_r) || (cyc_end && state_r == CSK_ST_SKIP2)
                   || (cyc_end && state_r == CSK_ST_SKIP1 && !two_r);
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flush_r <= 1'b0;
            nop_r <= 1'b0;
            done_r <= 1'b0;
            status_we_r <= 1'b0;
        end else if (ce) begin
            flush_r <= skip_go;
            done_r <= fin_nxt;
            status_we_r <= 1'b0;
            if (q4) begin
                nop_r <= nop_nxt;
            end
        end
    end

    // helper: instruction cycles spent and outcome, for checking only
    logic [1:0] cyc_h;
    logic took_h;
    logic two_h;
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cyc_h <= `CSK_CYC_RST;
            took_h <= 1'b0;
            two_h <= 1'b0;
        end else if (accept) begin
            cyc_h <= `CSK_CYC_RST;
            took_h <= 1'b0;
            two_h <= 1'b0;
        end else if (cyc_end && (act_r || !run)) begin
            cyc_h <= cyc_h + 2'h1;
            if (act_r) begin
                took_h <= take_r;
                two_h <= next_two_word;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_r);

    gt_decode_a: assert property (accept && is_gt |=> mem_r.rd_en && gt_r)
        else $error("greater-than word not decoded");
    lt_decode_a: assert property (accept && is_lt |=> mem_r.rd_en && !gt_r)
        else $error("less-than word not decoded");
    gt_compare_a: assert property (ce && q3 && act_r && gt_r
        |=> take_r == ($past(opnd_r) > $past(working_register)))
        else $error("greater-than compare wrong");
    lt_compare_a: assert property (ce && q3 && act_r && !gt_r
        |=> take_r == ($past(opnd_r) < $past(working_register)))
        else $error("less-than compare wrong");
    skip_nop_a: assert property (flush_r |-> nop_r && !run)
        else $error("skip without no-op cycle");
    access_bank_a: assert property (accept && !instr.bank_a
        |=> mem_r.addr[11:8] == ($past(acc_lo) ? `CSK_ACC_LO_BANK : `CSK_ACC_HI_BANK))
        else $error("access bank not used");
    sel_bank_a: assert property (accept && instr.bank_a
        |=> mem_r.addr == {$past(bank_select_register), $past(instr.faddr)})
        else $error("bank select not used");
    cycle_count_a: assert property (done_r && !(took_h && two_h)
        |-> cyc_h == (took_h ? `CSK_CYC_SKIP : `CSK_CYC_NOSKIP))
        else $error("wrong cycle count");
    two_word_a: assert property (done_r && took_h && two_h |-> cyc_h == `CSK_CYC_SKIP2W)
        else $error("two-word skip not three cycles");
    no_flags_a: assert property (status_we_r == 1'b0)
        else $error("status flags written");
    quiet_skip_a: assert property (!run |-> !mem_r.rd_en && !act_r)
        else $error("activity during skip cycle");
    read_phase_a: assert property (mem_r.rd_en |-> q2)
        else $error("operand read outside Q2");

    cover property (exec_end && !take_r);
    cover property (skip_go && gt_r);
    cover property (skip_go && !gt_r);
    cover property (cyc_end && state_r == CSK_ST_SKIP2);

endmodule // cskip_exec

// ==== cskip_cfg.svh ====
// constants for the compare-and-skip execution block
// assumes one core clock edge per instruction phase, four phases a cycle
`ifndef CSKIP_CFG_SVH
`define CSKIP_CFG_SVH

// opcode fields of the two compare-skip words
`define CSK_OP_HI 4'h6
`define CSK_GT_SEL 3'h2
`define CSK_LT_SEL 3'h0

// access bank split: low half maps to bank 0, high half to the top bank
`define CSK_ACC_SPLIT 8'h80
`define CSK_ACC_LO_BANK 4'h0
`define CSK_ACC_HI_BANK 4'hF

// phase codes, one-hot, and the reset values
`define CSK_PH_Q1 4'h1
`define CSK_PH_Q2 4'h2
`define CSK_PH_Q3 4'h4
`define CSK_PH_Q4 4'h8
`define CSK_ADDR_RST 12'h000
`define CSK_CYC_RST 2'h0

// instruction cycle counts: no skip, skip, skip over a two-word word
`define CSK_CYC_NOSKIP 2'h1
`define CSK_CYC_SKIP 2'h2
`define CSK_CYC_SKIP2W 2'h3

`endif

// ==== cskip_pkg.sv ====
// types shared by the compare-and-skip execution block
// takes nothing from cskip_cfg.svh; the state codes are literal here
package cskip_pkg;

    // execution state, one-hot
    typedef enum logic [2:0] {
        CSK_ST_RUN   = 3'b001,
        CSK_ST_SKIP1 = 3'b010,
        CSK_ST_SKIP2 = 3'b100
    } cskip_state_e;

    // one instruction word as the decoder sees it
    typedef struct packed {
        logic [3:0] op_hi;
        logic [2:0] sel;
        logic bank_a;
        logic [7:0] faddr;
    } cskip_instr_s;

    // data memory read request
    typedef struct packed {
        logic rd_en;
        logic [11:0] addr;
    } cskip_mem_s;

    // one-hot phase vector
    typedef logic [3:0] cskip_phase_t;

endpackage

// ==== cskip_phase.sv ====
// four-phase ring counter for the instruction cycle
// assumes a synchronised active-low reset and a clock enable
`timescale 1ns/1ps
`include "cskip_cfg.svh"
module cskip_phase
    import cskip_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // phase out
    output cskip_phase_t phase_r
);

    // rotate one-hot phase on every enabled edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= `CSK_PH_Q1;
        end else if (ce) begin
            phase_r <= {phase_r[2:0], phase_r[3]};
        end
    end

endmodule // cskip_phase

// ==== compare_skip_execution_bench.sv ====
// bench for the compare-and-skip execution block: table rows, then refusal, stall and reset
// assumes cskip_pkg is compiled first and cskip_cfg.svh is on the include path
`timescale 1ns/1ps
`include "cskip_cfg.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module compare_skip_execution_bench
    import cskip_pkg::*;
;
    // one table row: stimulus, then expected address and cycle count (0 = refused)
    typedef struct packed {
        logic [15:0] word;
        logic [7:0] work;
        logic [3:0] bank;
        logic [7:0] opnd;
        logic two;
        logic [11:0] addr;
        logic [1:0] cyc;
    } cskip_row_s;
    // design inputs
    logic clk;
    logic arst_n;
    logic ce;
    logic instr_valid;
    cskip_instr_s instr;
    logic next_two_word;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
    logic [7:0] mem_rdata;
    // design outputs
    cskip_mem_s mem_r;
    cskip_phase_t phase_r;
    logic flush_r;
    logic nop_r;
    logic done_r;
    logic status_we_r;
    // counters and scratch
    int miscompares;
    int checked;
    cskip_phase_t held;
    // ordinary cases: greater and less, both bank modes, equal and edge values
    cskip_row_s rows [0:7] = '{
        '{16'h6410, 8'h05, 4'h3, 8'h06, 1'h0, 12'h010, `CSK_CYC_SKIP},
        '{16'h6410, 8'h06, 4'h3, 8'h06, 1'h0, 12'h010, `CSK_CYC_NOSKIP},
        '{16'h6590, 8'hFE, 4'h3, 8'hFF, 1'h1, 12'h390, `CSK_CYC_SKIP2W},
        '{16'h6090, 8'h01, 4'h3, 8'h00, 1'h0, 12'hF90, `CSK_CYC_SKIP},
        '{16'h6090, 8'h00, 4'h3, 8'h00, 1'h1, 12'hF90, `CSK_CYC_NOSKIP},
        '{16'h61A5, 8'h80, 4'hC, 8'h7F, 1'h1, 12'hCA5, `CSK_CYC_SKIP2W},
        '{16'h657F, 8'hFF, 4'h5, 8'hFF, 1'h0, 12'h57F, `CSK_CYC_NOSKIP},
        '{16'h607F, 8'h80, 4'h5, 8'h81, 1'h0, 12'h07F, `CSK_CYC_NOSKIP}
    };

    cskip_exec cskip_exec_i (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .instr_valid(instr_valid),
        .instr(instr),
        .next_two_word(next_two_word),
        .working_register(working_register),
        .bank_select_register(bank_select_register),
        .mem_r(mem_r),
        .mem_rdata(mem_rdata),
        .phase_r(phase_r),
        .flush_r(flush_r),
        .nop_r(nop_r),
        .done_r(done_r),
        .status_we_r(status_we_r)
    );

    // counts, verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // outputs held at their reset values
    task automatic check_reset();
        `CHK(phase_r, `CSK_PH_Q1)
        `CHK(mem_r, 13'h0000)
        `CHK({flush_r, nop_r, done_r, status_we_r}, 4'h0)
    endtask

    // present one word at a first phase and follow it cycle by cycle
    task automatic run_row(input cskip_row_s r);
        int k;
        int last;
        logic skp;
        logic en;
        k = 0;
        en = r.cyc != 2'h0;
        skp = r.cyc > 2'h1;
        last = en ? int'(r.cyc) * 4 : 8;
        // bounded wait for the first phase
        while (phase_r !== `CSK_PH_Q1 && k < 8) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 8) begin
            miscompares++;
            complete_run();
        end
        instr = r.word;
        working_register = r.work;
        bank_select_register = r.bank;
        next_two_word = r.two;
        instr_valid = 1'h1;
        for (int n = 1; n <= last; n++) begin
            @(posedge clk);
            #1;
            // a word offered in the first skip cycle must be ignored
            instr_valid = skp && n == 4;
            // operand valid only across the read phase, inverted otherwise
            mem_rdata = (n == 1) ? r.opnd : ~r.opnd;
            `CHK(done_r, en && n == last)
            `CHK(flush_r, skp && n == 4)
            `CHK(nop_r, skp && n >= 4 && n < last)
            `CHK(mem_r.rd_en, en && n == 1)
            `CHK(status_we_r, 1'h0)
            if (en && n == 1) begin
                `CHK(mem_r.addr, r.addr)
                `CHK(phase_r, `CSK_PH_Q2)
            end
        end
    endtask

    // free-running clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        arst_n = 1'h0;
        ce = 1'h1;
        instr_valid = 1'h0;
        instr = 16'h0000;
        next_two_word = 1'h0;
        working_register = 8'h00;
        bank_select_register = 4'h0;
        mem_rdata = 8'h00;
        miscompares = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        #1;
        check_reset();
        arst_n = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        // table rows, back to back where no skip
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // words of other opcodes are ignored
        run_row('{16'h6210, 8'h00, 4'h0, 8'h01, 1'h0, 12'h000, 2'h0});
        run_row('{16'h5410, 8'h00, 4'h0, 8'h01, 1'h0, 12'h000, 2'h0});
        $display("refusal test done");
        // clock enable low in the read phase freezes the whole instruction
        instr = 16'h6410;
        working_register = 8'h05;
        next_two_word = 1'h0;
        mem_rdata = 8'h06;
        instr_valid = 1'h1;
        @(posedge clk);
        #1;
        instr_valid = 1'h0;
        ce = 1'h0;
        held = phase_r;
        repeat (3) @(posedge clk);
        #1;
        `CHK(phase_r, held)
        `CHK(mem_r.rd_en, 1'h1)
        ce = 1'h1;
        // seven enabled edges remain until the skip completes
        repeat (7) @(posedge clk);
        #1;
        `CHK(done_r, 1'h1)
        $display("stall test done");
        // second reset in mid-run, then a skip again
        arst_n = 1'h0;
        @(posedge clk);
        #1;
        check_reset();
        arst_n = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        run_row(rows[2]);
        $display("reset test done");
        complete_run();
    end
endmodule // compare_skip_execution_bench
